// file: common/touch_scan_regs.vh
`ifndef TOUCH_SCAN_REGS_VH
`define TOUCH_SCAN_REGS_VH

// Clock and scan timing
`define CLOCK_HZ            10000000
`define MS_PER_SECOND       1000
`define MIN_PERIOD_MS       11'd15
`define ACTIVE_PERIOD_MS    11'd30
`define DOZE_PERIOD_MS      11'd195
`define IDLE_PERIODS_DFLT   8'd100
`define FADE_INTERVAL_DFLT  8'd4

// Operating modes
`define MODE_ACTIVE         2'h0
`define MODE_DOZE           2'h1
`define MODE_SLEEP          2'h2

// Mode override codes
`define FORCE_NONE          2'h0
`define FORCE_ACTIVE        2'h1
`define FORCE_DOZE          2'h2
`define FORCE_SLEEP         2'h3

// Scan phases shown on the status port
`define PHASE_BOOT          2'h0
`define PHASE_SENSE         2'h1
`define PHASE_PROCESS       2'h2
`define PHASE_TIMER         2'h3

// Per-pin modes, two bits each
`define GPIO_FADE           2'h0
`define GPIO_DIRECT_PWM     2'h1
`define GPIO_PLAIN_INPUT    2'h2
`define GPIO_PLAIN_OUTPUT   2'h3

`define GPIO_COUNT          8
`define SENSE_COUNT         8
`define PWM_BITS            8

`endif

// file: design/led_pwm_channel.v
`include "touch_scan_regs.vh"

module led_pwm_channel #(
   parameter PWM_BITS = 8
) (
   input  wire                i_clock,
   input  wire                i_resetn,
   input  wire [1:0]          i_mode,
   input  wire                i_light_on,
   input  wire [PWM_BITS-1:0] i_direct_duty,
   input  wire                i_ms_tick,
   input  wire [7:0]          i_fade_interval,
   input  wire                i_fade_log,
   input  wire [PWM_BITS-1:0] i_fade_start,
   input  wire [PWM_BITS-1:0] i_fade_end,
   output reg                 o_pwm
);

   reg  [PWM_BITS-1:0]   pwm_count;
   reg  [PWM_BITS-1:0]   level;
   reg  [7:0]            interval_count;
   reg  [PWM_BITS-1:0]   duty;
   wire [2*PWM_BITS-1:0] level_sq;
   wire [PWM_BITS-1:0]   target;
   wire                  step;

   assign level_sq = level * level;
   assign target   = i_light_on ? i_fade_end : i_fade_start;
   assign step     = i_ms_tick && (interval_count >= i_fade_interval);

   // Duty select: direct width, curved or linear fade
   always @* begin
      if (i_mode == `GPIO_DIRECT_PWM)
         duty = i_direct_duty;
      else if (i_fade_log)
         duty = level_sq[2*PWM_BITS-1:PWM_BITS];
      else
         duty = level;
   end

   // Fade walks one step per interval towards the target
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         level          <= {PWM_BITS{1'b0}};
         interval_count <= 8'h00;
      end else begin
         if (i_ms_tick)
            interval_count <= step ? 8'h00 : interval_count + 8'h01;
         if (step && level < target)
            level <= level + 1'b1;
         else if (step && level > target)
            level <= level - 1'b1;
      end
   end

   // 256-step counter and compare
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         pwm_count <= {PWM_BITS{1'b0}};
         o_pwm     <= 1'b0;
      end else begin
         pwm_count <= pwm_count + 1'b1;
         if (i_mode == `GPIO_PLAIN_OUTPUT)
            o_pwm <= i_light_on;
         else
            o_pwm <= (pwm_count < duty);
      end
   end

endmodule

// file: design/touch_scan_top.v
`include "touch_scan_regs.vh"

// What this block does
// - Sense every enabled input in order from input 0 to input 7.
// - After sensing, process results and refresh pins and host status.
// - After processing, wait in low power until the period timer expires.
// - Host status, pin light requests and interrupt assertion change only in the processing phase.
// - Input pin changes after processing are reported one period later.
// - Host programs the scan period, at least 15 ms, beyond one second.
// - On touch, assert active-low interrupt at the end of processing.
// - Active mode uses a short period, 30 ms by default.
// - Doze mode uses a longer period, 195 ms by default.
// - Sleep mode does no sensing; period timer, processing and pin PWM keep running.
// - Separate active and doze periods; use the one of the current mode.
// - Inactivity timer moves active to doze; can be disabled.
// - Each pin has its own 256-step PWM generator.
// - Fading is curved or linear with selectable interval, start, end.
// - Autolight: touch fades mapped LED in, release fades it out.
// - Without autolight, host level high starts an autonomous fade-in.
// - Direct PWM mode outputs exactly the host duty, no fading.
// - Each pin can be a plain input reported to the host.
// - New information raises the interrupt and updates readable status.
// - Parameters load from the store at boot; host may overwrite later.
// - Default: input 0 touch lights pin 0, release fades it out slowly.
// - Default: inputs 2 to 7 form a slider lighting pins 2 to 7.
// - In doze, a touch on any button returns to active mode; with the wake sequence enabled, only once it is ok.
// - Host mode override forces the operating mode.
module touch_scan_top #(
   parameter CYCLES_PER_MS = `CLOCK_HZ / `MS_PER_SECOND,
   parameter PWM_BITS      = `PWM_BITS
) (
   input  wire                  i_clock,
   input  wire                  i_resetn,
   input  wire                  i_param_loaded,
   input  wire [7:0]            i_sense_enable,
   input  wire                  i_sense_done,
   input  wire                  i_sense_touched,
   input  wire [10:0]           i_active_period_ms,
   input  wire [10:0]           i_doze_period_ms,
   input  wire                  i_idle_enable,
   input  wire [7:0]            i_idle_periods,
   input  wire [1:0]            i_op_mode_override,
   input  wire                  i_wake_sequence_enable,
   input  wire                  i_wake_sequence_ok,
   input  wire                  i_autolight_enable,
   input  wire [7:0]            i_slider_map,
   input  wire [15:0]           i_gpio_mode,
   input  wire [7:0]            i_host_gpio_level,
   input  wire [8*PWM_BITS-1:0] i_host_pwm_duty,
   input  wire                  i_fade_log,
   input  wire [7:0]            i_fade_interval,
   input  wire [PWM_BITS-1:0]   i_fade_start,
   input  wire [PWM_BITS-1:0]   i_fade_end,
   input  wire [7:0]            i_gpio_pin,
   input  wire                  i_irq_clear,
   output reg                   o_sense_start,
   output reg  [2:0]            o_sense_index,
   output reg  [1:0]            o_scan_phase,
   output reg  [1:0]            o_op_mode,
   output reg  [7:0]            o_touch_status,
   output reg  [7:0]            o_gpio_in_status,
   output reg  [7:0]            o_gpio_out,
   output reg  [7:0]            o_gpio_oe,
   output reg                   o_host_irq_n
);

   // Scan sequencer states
   localparam [2:0] ST_BOOT    = 3'h0;
   localparam [2:0] ST_REQ     = 3'h1;
   localparam [2:0] ST_WAIT    = 3'h2;
   localparam [2:0] ST_PROCESS = 3'h3;
   localparam [2:0] ST_TIMER   = 3'h4;

   localparam integer MS_LAST_FULL = CYCLES_PER_MS - 1;
   localparam [15:0]  MS_LAST      = MS_LAST_FULL[15:0];

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [15:0] ms_prescale;
   reg         ms_tick;
   reg  [10:0] period_count;
   reg  [7:0]  idle_count;
   reg  [7:0]  touch_sample;
   reg  [7:0]  pin_meta;
   reg  [7:0]  pin_sync;
   reg  [7:0]  light_on;
   reg  [1:0]  next_mode;
   reg  [10:0] raw_period;
   reg  [10:0] period_ms;
   wire [7:0]  pwm_out;
   wire        any_touch;
   wire        period_done;
   wire        more_inputs;
   wire [7:0]  higher_enabled;
   wire [7:0]  next_touch;
   wire [7:0]  next_gpio_in;
   wire        news;

   assign any_touch   = |touch_sample;
   assign period_done = ms_tick && (period_count >= period_ms - 11'h001);

   // Inputs still to scan above the current index
   assign higher_enabled = i_sense_enable & ~((8'h02 << o_sense_index) - 8'h01);
   assign more_inputs    = |higher_enabled;

   // Status seen by the host after this processing phase
   assign next_touch   = (o_op_mode == `MODE_SLEEP) ? 8'h00 : touch_sample;
   assign next_gpio_in = pin_sync;
   assign news = (next_touch != o_touch_status) ||
                 ((next_gpio_in ^ o_gpio_in_status) != 8'h00);

   // Period of the current mode, raised to the floor
   always @* begin
      if (o_op_mode == `MODE_DOZE)
         raw_period = (i_doze_period_ms == 11'h000) ? `DOZE_PERIOD_MS
                                                    : i_doze_period_ms;
      else
         raw_period = (i_active_period_ms == 11'h000) ? `ACTIVE_PERIOD_MS
                                                      : i_active_period_ms;
      if (raw_period < `MIN_PERIOD_MS)
         period_ms = `MIN_PERIOD_MS;
      else
         period_ms = raw_period;
   end

   // Two-stage sync of the pins
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         pin_meta <= i_gpio_pin;
         pin_sync <= pin_meta;
      end
   end

   // Millisecond time base
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         ms_prescale <= 16'h0000;
         ms_tick     <= 1'b0;
      end else begin
         ms_tick <= (ms_prescale == MS_LAST);
         if (ms_prescale == MS_LAST)
            ms_prescale <= 16'h0000;
         else
            ms_prescale <= ms_prescale + 16'h0001;
      end
   end

   // Scan period counter runs from the start of sensing
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         period_count <= 11'h000;
      end else if (state == ST_BOOT || (state == ST_TIMER && period_done)) begin
         period_count <= 11'h000;
      end else if (ms_tick && period_count != 11'h7ff) begin
         period_count <= period_count + 11'h001;
      end
   end

   // Sequencer next state
   always @* begin
      next_state = state;
      case (state)
         ST_BOOT: begin
            if (i_param_loaded)
               next_state = ST_TIMER;
         end
         ST_REQ: begin
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (i_sense_done)
               next_state = more_inputs ? ST_REQ : ST_PROCESS;
         end
         ST_PROCESS: begin
            next_state = ST_TIMER;
         end
         ST_TIMER: begin
            if (period_done) begin
               if (o_op_mode == `MODE_SLEEP || i_sense_enable == 8'h00)
                  next_state = ST_PROCESS;
               else
                  next_state = ST_REQ;
            end
         end
         default: begin
            next_state = ST_BOOT;
         end
      endcase
   end

   // Sequencer state, input index and sensing strobe
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state         <= ST_BOOT;
         o_sense_index <= 3'h0;
         o_sense_start <= 1'b0;
         touch_sample  <= 8'h00;
      end else begin
         state         <= next_state;
         o_sense_start <= (next_state == ST_REQ);
         if (state == ST_TIMER && next_state == ST_REQ) begin
            o_sense_index <= 3'h0;
            touch_sample  <= 8'h00;
            if (!i_sense_enable[0])
               o_sense_index <= first_enabled(i_sense_enable);
         end else if (state == ST_WAIT && i_sense_done) begin
            touch_sample[o_sense_index] <= i_sense_touched;
            if (more_inputs)
               o_sense_index <= first_enabled(higher_enabled);
         end
      end
   end

   // Lowest set bit of a mask
   function [2:0] first_enabled;
      input [7:0] mask;
      integer     k;
      begin
         first_enabled = 3'h7;
         for (k = 7; k >= 0; k = k - 1)
            if (mask[k])
               first_enabled = k[2:0];
      end
   endfunction

   // Operating mode choice at processing
   always @* begin
      next_mode = o_op_mode;
      case (i_op_mode_override)
         `FORCE_ACTIVE: next_mode = `MODE_ACTIVE;
         `FORCE_DOZE:   next_mode = `MODE_DOZE;
         `FORCE_SLEEP:  next_mode = `MODE_SLEEP;
         default: begin
            if (o_op_mode == `MODE_SLEEP)
               next_mode = `MODE_ACTIVE;
            else if (o_op_mode == `MODE_DOZE && any_touch &&
                     (!i_wake_sequence_enable || i_wake_sequence_ok))
               next_mode = `MODE_ACTIVE;
            else if (o_op_mode == `MODE_ACTIVE && i_idle_enable && !any_touch &&
                     idle_count >= i_idle_periods)
               next_mode = `MODE_DOZE;
         end
      endcase
   end

   // Mode and inactivity count update once per period
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_op_mode  <= `MODE_ACTIVE;
         idle_count <= 8'h00;
      end else if (state == ST_BOOT) begin
         o_op_mode  <= `MODE_ACTIVE;
         idle_count <= 8'h00;
      end else if (state == ST_PROCESS) begin
         o_op_mode <= next_mode;
         if (any_touch || next_mode != `MODE_ACTIVE)
            idle_count <= 8'h00;
         else if (idle_count != 8'hff)
            idle_count <= idle_count + 8'h01;
      end
   end

   // Host status, LED requests and interrupt
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_touch_status   <= 8'h00;
         o_gpio_in_status <= 8'h00;
         light_on         <= 8'h00;
         o_host_irq_n     <= 1'b1;
      end else begin
         if (state == ST_PROCESS) begin
            o_touch_status   <= next_touch;
            o_gpio_in_status <= next_gpio_in;
            if (i_autolight_enable)
               light_on <= (next_touch & ~i_slider_map) |
                           ((|(next_touch & i_slider_map)) ?
                            (next_touch & i_slider_map) : 8'h00);
            else
               light_on <= i_host_gpio_level;
         end
         // Set wins over a clear in the same cycle
         if (state == ST_PROCESS && news)
            o_host_irq_n <= 1'b0;
         else if (i_irq_clear)
            o_host_irq_n <= 1'b1;
      end
   end

   // Pin drivers and enables registered every cycle
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_gpio_out <= 8'h00;
         o_gpio_oe  <= 8'h00;
      end else begin
         o_gpio_out <= pwm_out;
         o_gpio_oe  <= oe_mask(i_gpio_mode);
      end
   end

   // Output enable per pin from its mode
   function [7:0] oe_mask;
      input [15:0] modes;
      integer      m;
      begin
         oe_mask = 8'h00;
         for (m = 0; m < 8; m = m + 1)
            oe_mask[m] = (modes[2*m +: 2] != `GPIO_PLAIN_INPUT);
      end
   endfunction

   // One fader and PWM generator per pin
   genvar g;
   generate
      for (g = 0; g < `GPIO_COUNT; g = g + 1) begin : gen_pin
         led_pwm_channel #(
            .PWM_BITS (PWM_BITS)
         ) u_channel (
            .i_clock         (i_clock),
            .i_resetn        (i_resetn),
            .i_mode          (i_gpio_mode[2*g +: 2]),
            .i_light_on      (light_on[g]),
            .i_direct_duty   (i_host_pwm_duty[PWM_BITS*g +: PWM_BITS]),
            .i_ms_tick       (ms_tick),
            .i_fade_interval (i_fade_interval),
            .i_fade_log      (i_fade_log),
            .i_fade_start    (i_fade_start),
            .i_fade_end      (i_fade_end),
            .o_pwm           (pwm_out[g])
         );
      end
   endgenerate

   // Phase shown to the outside
   always @* begin
      case (state)
         ST_BOOT:    o_scan_phase = `PHASE_BOOT;
         ST_REQ:     o_scan_phase = `PHASE_SENSE;
         ST_WAIT:    o_scan_phase = `PHASE_SENSE;
         ST_PROCESS: o_scan_phase = `PHASE_PROCESS;
         default:    o_scan_phase = `PHASE_TIMER;
      endcase
   end

   // Factory defaults (input i lights pin i, slider 2..7) come from the
   // parameter store through i_slider_map and i_gpio_mode

endmodule

// file: sim/touch_scan_top_sva.sv
`include "touch_scan_regs.vh"

module touch_scan_top_sva (
   input logic       i_clock,
   input logic       i_resetn,
   input logic [7:0] i_sense_enable,
   input logic       i_irq_clear,
   input logic       o_sense_start,
   input logic [2:0] o_sense_index,
   input logic [1:0] o_scan_phase,
   input logic [1:0] o_op_mode,
   input logic [7:0] o_touch_status,
   input logic [7:0] o_gpio_in_status,
   input logic       o_host_irq_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   logic       seen;
   logic [2:0] last;

   // Last index started in the current sensing phase
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         seen <= 1'b0;
         last <= 3'h0;
      end else if (o_scan_phase != `PHASE_SENSE) begin
         seen <= 1'b0;
      end else if (o_sense_start) begin
         seen <= 1'b1;
         last <= o_sense_index;
      end
   end

   chk_index_rising: assert property (
      o_sense_start && seen |-> o_sense_index > last) else $error("index not ascending");
   chk_index_enabled: assert property (
      o_sense_start |-> i_sense_enable[o_sense_index]) else $error("disabled input sensed");
   chk_start_sensing: assert property (
      o_sense_start |-> o_scan_phase == `PHASE_SENSE) else $error("start outside sensing");
   chk_process_single: assert property (
      o_scan_phase == `PHASE_PROCESS |=> o_scan_phase == `PHASE_TIMER)
      else $error("processing not followed by timer");
   chk_touch_update: assert property (
      $changed(o_touch_status) |-> $past(o_scan_phase) == `PHASE_PROCESS)
      else $error("touch status changed outside processing");
   chk_input_update: assert property (
      $changed(o_gpio_in_status) |-> $past(o_scan_phase) == `PHASE_PROCESS)
      else $error("input status changed outside processing");
   chk_irq_set: assert property (
      $fell(o_host_irq_n) |-> $past(o_scan_phase) == `PHASE_PROCESS)
      else $error("irq set outside processing");
   chk_irq_cause: assert property (
      $changed(o_touch_status) || $changed(o_gpio_in_status) |-> !o_host_irq_n)
      else $error("status change without irq");
   chk_irq_release: assert property (
      $rose(o_host_irq_n) |-> $past(i_irq_clear)) else $error("irq released without clear");
   chk_sleep_quiet: assert property (
      o_op_mode == `MODE_SLEEP && $past(o_op_mode) == `MODE_SLEEP |-> !o_sense_start)
      else $error("sensing in sleep");
endmodule

bind touch_scan_top touch_scan_top_sva chk (
   .i_clock         (i_clock),
   .i_resetn        (i_resetn),
   .i_sense_enable  (i_sense_enable),
   .i_irq_clear     (i_irq_clear),
   .o_sense_start   (o_sense_start),
   .o_sense_index   (o_sense_index),
   .o_scan_phase    (o_scan_phase),
   .o_op_mode       (o_op_mode),
   .o_touch_status  (o_touch_status),
   .o_gpio_in_status(o_gpio_in_status),
   .o_host_irq_n    (o_host_irq_n)
);

// file: sim/sense_front_model.sv
module sense_front_model (
   input  logic       i_clock,
   input  logic       i_start,
   input  logic [2:0] i_index,
   input  logic [7:0] i_touch_mask,
   input  logic       i_slow,
   output logic       o_done,
   output logic       o_touched
);
   timeunit 1ns;
   timeprecision 1ns;
   int   wait_cnt = -1;
   logic bit_now = 1'b0;

   initial begin
      o_done = 1'b0;
      o_touched = 1'b0;
   end

   // Answer each start after a short or long conversion
   always @(posedge i_clock) begin
      o_done <= 1'b0;
      o_touched <= ~o_touched; // Result line invalid outside done
      if (i_start) begin
         wait_cnt <= i_slow ? 6 : 1;
         bit_now <= i_touch_mask[i_index];
      end else if (wait_cnt == 0) begin
         o_done <= 1'b1;
         o_touched <= bit_now;
         wait_cnt <= -1;
      end else if (wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
endmodule

// file: sim/touch_scan_top_tb.sv
`include "touch_scan_regs.vh"

module touch_scan_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clock = 1'b0, i_resetn = 1'b0, i_param_loaded = 1'b0;
   logic [7:0]  i_sense_enable = 8'hb5;
   logic        i_sense_done, i_sense_touched;
   logic [10:0] i_active_period_ms = 11'h00f, i_doze_period_ms = 11'h014;
   logic        i_idle_enable = 1'b0, i_wake_sequence_enable = 1'b0, i_wake_sequence_ok = 1'b0;
   logic [7:0]  i_idle_periods = 8'h02, i_slider_map = 8'hfc, i_host_gpio_level = 8'h00;
   logic [1:0]  i_op_mode_override = `FORCE_NONE;
   logic        i_autolight_enable = 1'b0, i_fade_log = 1'b0, i_irq_clear = 1'b0, slow = 1'b0;
   logic [15:0] i_gpio_mode = 16'hf8f4;
   logic [63:0] i_host_pwm_duty = 64'h0;
   logic [7:0]  i_fade_interval = 8'h00, i_fade_start = 8'h00, i_fade_end = 8'hff;
   logic [7:0]  i_gpio_pin = 8'h00, touch_mask = 8'h00;
   logic        o_sense_start, o_host_irq_n;
   logic [2:0]  o_sense_index;
   logic [1:0]  o_scan_phase, o_op_mode, phase_q = 2'h0;
   logic [7:0]  o_touch_status, o_gpio_in_status, o_gpio_out, o_gpio_oe;
   logic [10:0] pset [3] = '{11'h005, 11'h00f, 11'h000};
   logic [7:0]  dset [3] = '{8'h00, 8'h40, 8'hff};
   int          pexp [3] = '{150, 150, 300};
   int          err_total = 0, comparisons = 0, cycles = 0, starts = 0, span = 0, last_sense = 0;

   touch_scan_top #(.CYCLES_PER_MS(10)) uut (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_param_loaded(i_param_loaded),
      .i_sense_enable(i_sense_enable), .i_sense_done(i_sense_done),
      .i_sense_touched(i_sense_touched), .i_active_period_ms(i_active_period_ms),
      .i_doze_period_ms(i_doze_period_ms), .i_idle_enable(i_idle_enable),
      .i_idle_periods(i_idle_periods), .i_op_mode_override(i_op_mode_override),
      .i_wake_sequence_enable(i_wake_sequence_enable),
      .i_wake_sequence_ok(i_wake_sequence_ok), .i_autolight_enable(i_autolight_enable),
      .i_slider_map(i_slider_map), .i_gpio_mode(i_gpio_mode),
      .i_host_gpio_level(i_host_gpio_level), .i_host_pwm_duty(i_host_pwm_duty),
      .i_fade_log(i_fade_log), .i_fade_interval(i_fade_interval),
      .i_fade_start(i_fade_start), .i_fade_end(i_fade_end), .i_gpio_pin(i_gpio_pin),
      .i_irq_clear(i_irq_clear), .o_sense_start(o_sense_start),
      .o_sense_index(o_sense_index), .o_scan_phase(o_scan_phase), .o_op_mode(o_op_mode),
      .o_touch_status(o_touch_status), .o_gpio_in_status(o_gpio_in_status),
      .o_gpio_out(o_gpio_out), .o_gpio_oe(o_gpio_oe), .o_host_irq_n(o_host_irq_n)
   );

   sense_front_model front (
      .i_clock(i_clock), .i_start(o_sense_start), .i_index(o_sense_index),
      .i_touch_mask(touch_mask), .i_slow(slow), .o_done(i_sense_done),
      .o_touched(i_sense_touched)
   );

   always #50 i_clock = ~i_clock;

   // Cycle count, start count, period span and hang limit
   always @(posedge i_clock) begin
      cycles++;
      phase_q <= o_scan_phase;
      if (o_sense_start) starts++;
      if (o_scan_phase == `PHASE_SENSE && phase_q != `PHASE_SENSE) begin
         span = cycles - last_sense;
         last_sense = cycles;
      end
      if (cycles == 60000) begin
         err_total++;
         summarize();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   function automatic logic near(input int a, input int b);
      return a >= b - 10 && a <= b + 10;
   endfunction

   // Wait past the next processing cycle until its updates have landed
   task automatic scan;
      int n;
      n = 0;
      while (o_scan_phase !== `PHASE_PROCESS && n < 5000) begin
         @(negedge i_clock);
         n++;
      end
      if (n == 5000) err_total++;
      repeat (3) @(negedge i_clock);
   endtask

   // High cycles of one pin over one 256 step frame
   task automatic duty(input int pin, output int hi);
      hi = 0;
      repeat (256) begin
         @(negedge i_clock);
         hi += o_gpio_out[pin];
      end
   endtask

   task automatic fade(input int pin, input int exp);
      int h;
      scan();
      repeat (3000) @(negedge i_clock);
      duty(pin, h);
      check("fade duty", 16'(h), 16'(exp));
   endtask

   task automatic clear_irq;
      @(posedge i_clock);
      i_irq_clear <= 1'b1;
      @(posedge i_clock);
      i_irq_clear <= 1'b0;
      @(negedge i_clock);
   endtask

   // Main sequence
   initial begin
      int s;
      int h;
      repeat (16) @(negedge i_clock);
      check("irq in reset", o_host_irq_n, 1);
      check("mode in reset", o_op_mode, `MODE_ACTIVE);
      @(posedge i_clock);
      i_resetn <= 1'b1;
      repeat (20) @(negedge i_clock);
      check("boot hold", o_scan_phase, `PHASE_BOOT);
      @(posedge i_clock);
      i_param_loaded <= 1'b1;
      scan();
      s = starts;
      scan();
      check("starts per scan", 16'(starts - s), 16'h0005);
      $display("test boot done");
      foreach (pset[i]) begin
         @(posedge i_clock);
         i_active_period_ms <= pset[i];
         repeat (3) scan();
         check("active span", near(span, pexp[i]), 1);
      end
      @(posedge i_clock);
      slow <= 1'b1;
      i_op_mode_override <= `FORCE_DOZE;
      repeat (3) scan();
      check("forced doze", o_op_mode, `MODE_DOZE);
      check("doze span", near(span, 200), 1);
      @(posedge i_clock);
      i_op_mode_override <= `FORCE_ACTIVE;
      scan();
      check("forced active", o_op_mode, `MODE_ACTIVE);
      @(posedge i_clock);
      i_op_mode_override <= `FORCE_SLEEP;
      repeat (2) scan();
      s = starts;
      scan();
      check("sleep mode", o_op_mode, `MODE_SLEEP);
      check("sleep starts", 16'(starts - s), 16'h0000);
      @(posedge i_clock);
      i_op_mode_override <= `FORCE_NONE;
      i_idle_enable <= 1'b1;
      h = 0;
      while (o_op_mode !== `MODE_DOZE && h < 8) begin
         scan();
         h++;
      end
      check("idle doze", o_op_mode, `MODE_DOZE);
      @(posedge i_clock);
      touch_mask <= 8'h04;
      i_wake_sequence_enable <= 1'b1;
      repeat (2) scan();
      check("wake held", o_op_mode, `MODE_DOZE);
      @(posedge i_clock);
      i_wake_sequence_ok <= 1'b1;
      scan();
      check("wake active", o_op_mode, `MODE_ACTIVE);
      check("touch status", o_touch_status, 8'h04);
      check("touch irq", o_host_irq_n, 0);
      clear_irq();
      check("irq cleared", o_host_irq_n, 1);
      scan();
      check("irq once", o_host_irq_n, 1);
      @(posedge i_clock);
      touch_mask <= 8'h00;
      i_idle_enable <= 1'b0;
      repeat (6) scan();
      check("idle off", o_op_mode, `MODE_ACTIVE);
      $display("test modes done");
      check("input oe", o_gpio_oe, 8'hdf);
      @(posedge i_clock);
      i_gpio_pin <= 8'h20;
      repeat (20) @(negedge i_clock);
      check("input held", o_gpio_in_status, 8'h00);
      scan();
      check("input seen", o_gpio_in_status, 8'h20);
      @(posedge i_clock);
      i_host_gpio_level <= 8'h04;
      scan();
      check("plain out", o_gpio_out[3:2], 2'h1);
      foreach (dset[i]) begin
         @(posedge i_clock);
         i_host_pwm_duty[15:8] <= dset[i];
         repeat (600) @(negedge i_clock);
         duty(1, h);
         check("direct duty", 16'(h), dset[i]);
      end
      $display("test pins done");
      @(posedge i_clock);
      i_host_gpio_level <= 8'h05;
      fade(0, 255);
      @(posedge i_clock);
      i_host_gpio_level <= 8'h04;
      i_fade_log <= 1'b1;
      fade(0, 0);
      @(posedge i_clock);
      i_fade_log <= 1'b0;
      i_autolight_enable <= 1'b1;
      touch_mask <= 8'h11;
      fade(0, 255);
      duty(4, h);
      check("slider led", 16'(h), 16'h00ff);
      @(posedge i_clock);
      i_fade_log <= 1'b1;
      i_fade_start <= 8'h40;
      touch_mask <= 8'h10;
      fade(0, 16);
      $display("test fading done");
      summarize();
   end
endmodule
